//--- shared/flash_pkg.sv
// Constants shared by the flash program/erase control block.
// Assumes a 16-bit byte address space seen through an AXI4-Lite slave.
package flash_pkg;
  // Bus clock and the lowest rate at which the pump may run an operation.
  localparam int unsigned BUS_CLK_HZ    = 50_000_000;
  localparam int unsigned MIN_OP_CLK_HZ = 2_000_000;
  localparam logic        PUMP_OK       = (BUS_CLK_HZ >= MIN_OP_CLK_HZ);

  // Address map, byte addresses.
  localparam logic [15:0] CTRL_ADDR    = 16'hfe08;
  localparam logic [15:0] PROTECT_ADDR = 16'hfff0;
  localparam logic [15:0] USER_FIRST   = 16'h7800;
  localparam logic [15:0] USER_LAST    = 16'h7fee;
  localparam logic [15:0] TRIM_ADDR    = 16'h7fef;
  localparam logic [15:0] VECTOR_FIRST = 16'hfff2;
  localparam logic [15:0] VECTOR_LAST  = 16'hffff;
  localparam int unsigned USER_BYTES   = 2031;
  localparam int unsigned VECTOR_BYTES = 14;
  localparam int unsigned ROW_BYTES    = 8;
  localparam int unsigned ARRAY_AW     = 11;

  // Control register field positions and reset value.
  localparam int unsigned BIT_PGM    = 0;
  localparam int unsigned BIT_ERASE  = 1;
  localparam int unsigned BIT_MARGIN = 2;
  localparam int unsigned BIT_HIGH_VOLTAGE_ENABLE   = 3;
  localparam int unsigned BIT_ERASE_SIZE_LOW   = 4;
  localparam int unsigned BIT_ERASE_SIZE_HIGH   = 5;
  localparam int unsigned BIT_FDIV   = 6;
  localparam int unsigned BIT_BUSY   = 7;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // Cared address bits of the erase block for each size code.
  localparam logic [10:0] MASK_FULL = 11'h000;
  localparam logic [10:0] MASK_HALF = 11'h400;
  localparam logic [10:0] MASK_64   = 11'h7c0;
  localparam logic [10:0] MASK_ROW  = 11'h7f8;

  // First protected array index for each protect bit.
  localparam logic [10:0] PROT_START0 = 11'h000;
  localparam logic [10:0] PROT_START1 = 11'h080;
  localparam logic [10:0] PROT_START2 = 11'h100;
  localparam logic [10:0] PROT_START3 = 11'h200;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_ERASE = 3'b010,
    OP_PROG  = 3'b100
  } op_state_e;
endpackage

//--- src/flash_cell_array.sv
// Byte array of the non-volatile store, indexed by the low 11 address bits.
// Assumes at most one of clear_en and prog_en per cycle.
`timescale 1ns/1ps
`default_nettype none
module flash_cell_array (
  input  wire logic        clk,
  input  wire logic        clear_en,
  input  wire logic        prog_en,
  input  wire logic [10:0] wr_idx,
  input  wire logic [7:0]  wr_data,
  input  wire logic [8:0]  rd_word_idx,
  output logic      [31:0] rd_word
);
  // The array ships erased; contents survive reset as real cells would.
  // A declaration value keeps the clocked process the only writer.
  logic [7:0] mem [0:2047] = '{default: 8'h00};

  // Erase drives cells to zero, programming can only set ones.
  always_ff @(posedge clk) begin
    if (clear_en) begin
      mem[wr_idx] <= 8'h00; // R1
    end else if (prog_en) begin
      mem[wr_idx] <= mem[wr_idx] | wr_data; // R1
    end
  end

  // Word read, lane 0 holds the lowest byte address.
  assign rd_word = {mem[{rd_word_idx, 2'h3}], mem[{rd_word_idx, 2'h2}],
                    mem[{rd_word_idx, 2'h1}], mem[{rd_word_idx, 2'h0}]};
endmodule
`default_nettype wire

//--- src/flash_program_erase_control.sv
// Program/erase sequencer, control register and AXI4-Lite slave.
// Assumes REF_CLK is the bus clock and RSTN a synchronous system reset.
//
// Behaviour
// R1 - Erased cells read zero, programmed cells read one.
// R2 - Store holds 2031 user bytes, 14 vector bytes and one protect byte.
// R3 - User 7800-7FEE, control FE08, protect FFF0, vectors FFF2-FFFF.
// R4 - Rows of eight one-byte pages; each program writes exactly one byte.
// R5 - Erase works on whole blocks, smallest being one eight-byte row.
// R6 - High voltage sets only with program or erase and sequence followed.
// R7 - High-voltage bit drives pump on and array high voltage.
// R8 - Margin bit cannot set while high voltage is on.
// R9 - Program and erase selects are never both set.
// R10 - Pump clock is bus clock divided by one or two.
// R11 - No operation runs with the bus clock below 2 MHz.
// R12 - Software picks the divider for a pump clock near 2 MHz.
// R13 - Software erases a row after eight programs to it.
// R14 - All control bits are readable and writable; here the busy bit (bit 7) is read-only.
// R15 - Block bits choose full array, half, eight rows or one row.
// R16 - First array write after erase select fixes the block address.
// R17 - Protect read latches; protected range clears program or erase.
// R18 - Control bits are all zero after reset.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control (
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic [15:0] S_AWADDR,
  input  wire logic        S_AWVALID,
  output var  logic        S_AWREADY,
  input  wire logic [31:0] S_WDATA,
  input  wire logic [3:0]  S_WSTRB,
  input  wire logic        S_WVALID,
  output var  logic        S_WREADY,
  output var  logic [1:0]  S_BRESP,
  output var  logic        S_BVALID,
  input  wire logic        S_BREADY,
  input  wire logic [15:0] S_ARADDR,
  input  wire logic        S_ARVALID,
  output var  logic        S_ARREADY,
  output var  logic [31:0] S_RDATA,
  output var  logic [1:0]  S_RRESP,
  output var  logic        S_RVALID,
  input  wire logic        S_RREADY,
  output var  logic        PUMP_ON,
  output var  logic        ARRAY_HV,
  output wire logic        PUMP_CLK_TICK
);
  logic                aw_held;
  logic [15:0]         aw_addr;
  logic                w_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                do_write;
  logic                do_read;
  logic                next_aw_held;
  logic                next_w_held;
  logic                next_bvalid;
  logic                next_rvalid;
  logic                program_select;
  logic                erase;
  logic                margin;
  logic                high_voltage_enable;
  logic                fdiv;
  logic [1:0]          blk;
  logic                next_pgm;
  logic                next_erase;
  logic                next_margin;
  logic                next_high_voltage_enable;
  logic                bpr_seen;
  logic [3:0]          bpr;
  logic                addr_seen;
  logic [10:0]         addr;
  logic [7:0]          data;
  logic [10:0]         mask;
  logic [10:0]         range_end;
  logic [10:0]         prot_start;
  logic                prot_hit;
  flash_pkg::op_state_e state;
  logic [10:0]         ptr;
  logic [10:0]         last;
  logic                hv_rise;
  logic                wr_ctrl;
  logic                wr_array;
  logic [1:0]          lane;
  logic [7:0]          ctrl_byte;
  logic [31:0]         rd_word;
  logic                tick;

  // Array bytes live at their low 11 address bits, so the user space
  // and the protect/vector bytes share one index space.
  function automatic logic is_array(input logic [15:0] a);
    is_array = (a[15:11] == flash_pkg::USER_FIRST[15:11]
                && a <= flash_pkg::TRIM_ADDR)
               || a[15:4] == flash_pkg::PROTECT_ADDR[15:4]; // R2 R3
  endfunction

  // A page is one byte; the lowest enabled lane is the one programmed.
  function automatic logic [1:0] first_lane(input logic [3:0] s);
    casez (s)
      4'b???1: first_lane = 2'h0;
      4'b??10: first_lane = 2'h1;
      4'b?100: first_lane = 2'h2;
      default: first_lane = 2'h3;
    endcase
  endfunction

  pump_clock_divider u_div (
    .clk        (REF_CLK),
    .rst_n      (RSTN),
    .div_by_two (fdiv),
    .tick       (tick)
  );
  assign PUMP_CLK_TICK = tick;

  flash_cell_array u_array (
    .clk         (REF_CLK),
    .clear_en    (state == flash_pkg::OP_ERASE && tick && high_voltage_enable),
    .prog_en     (state == flash_pkg::OP_PROG && tick && high_voltage_enable),
    .wr_idx      (ptr),
    .wr_data     (data),
    .rd_word_idx (S_ARADDR[10:2]),
    .rd_word     (rd_word)
  );

  // Write address and data are taken in either order; the write is
  // done once both are held and no response is pending.
  assign do_write     = aw_held && w_held && !S_BVALID;
  assign do_read      = S_ARVALID && S_ARREADY;
  assign next_aw_held = (aw_held || (S_AWVALID && S_AWREADY)) && !do_write;
  assign next_w_held  = (w_held || (S_WVALID && S_WREADY)) && !do_write;
  assign next_bvalid  = do_write || (S_BVALID && !S_BREADY);
  assign next_rvalid  = do_read || (S_RVALID && !S_RREADY);
  assign wr_ctrl      = do_write && aw_addr == flash_pkg::CTRL_ADDR
                        && w_strb[0];
  assign wr_array     = do_write && is_array(aw_addr) && (|w_strb);
  assign lane         = first_lane(w_strb);

  // Write channel handshake and response.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 16'h0000;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
      S_BVALID  <= 1'b0;
      S_BRESP   <= flash_pkg::RESP_OKAY;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      S_AWREADY <= !next_aw_held && !next_bvalid;
      S_WREADY  <= !next_w_held && !next_bvalid;
      S_BVALID  <= next_bvalid;
      if (S_AWVALID && S_AWREADY) begin
        aw_addr <= S_AWADDR;
      end
      if (S_WVALID && S_WREADY) begin
        w_data <= S_WDATA;
        w_strb <= S_WSTRB;
      end
      if (do_write) begin
        S_BRESP <= (aw_addr == flash_pkg::CTRL_ADDR || is_array(aw_addr))
                   ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel; reserved bytes read as zero, unmapped words error.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RDATA   <= 32'h0000_0000;
      S_RRESP   <= flash_pkg::RESP_OKAY;
    end else begin
      S_ARREADY <= !next_rvalid;
      S_RVALID  <= next_rvalid;
      if (do_read) begin
        S_RRESP <= flash_pkg::RESP_OKAY;
        S_RDATA <= 32'h0000_0000;
        if (S_ARADDR == flash_pkg::CTRL_ADDR) begin
          S_RDATA <= {24'h00_0000, ctrl_byte}; // R14
        end else if (S_ARADDR[15:2] == flash_pkg::TRIM_ADDR[15:2]) begin
          S_RDATA <= {8'h00, rd_word[23:0]};
        end else if (S_ARADDR[15:2] == flash_pkg::PROTECT_ADDR[15:2]) begin
          S_RDATA <= {rd_word[31:16], 8'h00, rd_word[7:0]};
        end else if (is_array(S_ARADDR)) begin
          S_RDATA <= rd_word;
        end else begin
          S_RRESP <= flash_pkg::RESP_SLVERR;
        end
      end
    end
  end

  assign ctrl_byte = {state != flash_pkg::OP_IDLE, fdiv, blk, high_voltage_enable,
                      margin, erase, program_select}; // R14

  // Erase extent from the block-size bits.
  always_comb begin
    unique case (blk)
      2'b00: mask = flash_pkg::MASK_FULL; // R15
      2'b01: mask = flash_pkg::MASK_HALF;
      2'b10: mask = flash_pkg::MASK_64;
      2'b11: mask = flash_pkg::MASK_ROW; // R5
    endcase
  end
  assign range_end = erase ? (addr | ~mask) : addr;

  // The lowest set protect bit decides where protection starts.
  always_comb begin
    if (bpr[0]) begin
      prot_start = flash_pkg::PROT_START0;
    end else if (bpr[1]) begin
      prot_start = flash_pkg::PROT_START1;
    end else if (bpr[2]) begin
      prot_start = flash_pkg::PROT_START2;
    end else begin
      prot_start = flash_pkg::PROT_START3;
    end
  end
  assign prot_hit = bpr_seen && addr_seen && (program_select || erase) && (|bpr)
                    && range_end >= prot_start; // R17

  // Next control bits with every interlock applied after the write.
  always_comb begin
    next_pgm    = program_select;
    next_erase  = erase;
    next_margin = margin;
    next_high_voltage_enable   = high_voltage_enable;
    if (wr_ctrl) begin
      next_pgm   = w_data[flash_pkg::BIT_PGM]
                   && (program_select || (!w_data[flash_pkg::BIT_ERASE] && !erase));
      next_erase = w_data[flash_pkg::BIT_ERASE]
                   && (erase || (!w_data[flash_pkg::BIT_PGM] && !program_select)); // R9
      next_high_voltage_enable  = w_data[flash_pkg::BIT_HIGH_VOLTAGE_ENABLE] && (next_pgm || next_erase)
                   && bpr_seen && addr_seen && flash_pkg::PUMP_OK; // R6 R11
      next_margin = w_data[flash_pkg::BIT_MARGIN] && !high_voltage_enable
                    && !next_high_voltage_enable; // R8
    end
    if (prot_hit) begin
      next_pgm   = 1'b0; // R17
      next_erase = 1'b0;
      next_high_voltage_enable  = 1'b0;
    end
  end

  // Control register; every bit is clear after reset.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {fdiv, blk, high_voltage_enable, margin, erase, program_select} <= flash_pkg::CTRL_RESET[6:0]; // R18
    end else begin
      program_select    <= next_pgm;
      erase  <= next_erase;
      margin <= next_margin;
      high_voltage_enable   <= next_high_voltage_enable;
      if (wr_ctrl) begin
        fdiv <= w_data[flash_pkg::BIT_FDIV]; // R14
        blk  <= {w_data[flash_pkg::BIT_ERASE_SIZE_HIGH], w_data[flash_pkg::BIT_ERASE_SIZE_LOW]};
      end
    end
  end

  // Sequence tracking: protect read, then the address-latching write.
  // Dropping both selects restarts the sequence.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      bpr_seen  <= 1'b0;
      bpr       <= 4'h0;
      addr_seen <= 1'b0;
      addr      <= 11'h000;
      data      <= 8'h00;
    end else if (!program_select && !erase) begin
      bpr_seen  <= 1'b0;
      addr_seen <= 1'b0;
    end else begin
      if (do_read && S_ARADDR[15:2] == flash_pkg::PROTECT_ADDR[15:2]) begin
        bpr_seen <= 1'b1; // R17
        bpr      <= rd_word[3:0];
      end
      if (wr_array && !addr_seen && !high_voltage_enable) begin
        addr_seen <= 1'b1; // R16
        addr      <= {aw_addr[10:2], lane}; // R4
        data      <= w_data[8 * lane +: 8];
      end
    end
  end

  // High voltage follows its bit one cycle later; the rise starts work.
  assign hv_rise = high_voltage_enable && !PUMP_ON;
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      PUMP_ON  <= 1'b0;
      ARRAY_HV <= 1'b0;
    end else begin
      PUMP_ON  <= high_voltage_enable; // R7
      ARRAY_HV <= high_voltage_enable;
    end
  end

  // Operation sequencer: one byte per pump tick while high voltage holds.
  // Dropping high voltage early abandons the rest of the block.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state <= flash_pkg::OP_IDLE;
      ptr   <= 11'h000;
      last  <= 11'h000;
    end else begin
      unique case (state)
        flash_pkg::OP_IDLE: begin
          if (hv_rise && erase) begin
            state <= flash_pkg::OP_ERASE;
            ptr   <= addr & mask; // R5
            last  <= range_end;
          end else if (hv_rise && program_select) begin
            state <= flash_pkg::OP_PROG;
            ptr   <= addr; // R4
            last  <= addr;
          end
        end
        flash_pkg::OP_ERASE: begin
          if (!high_voltage_enable || (tick && ptr == last)) begin
            state <= flash_pkg::OP_IDLE;
          end else if (tick) begin
            ptr <= ptr + 11'h001; // R5
          end
        end
        flash_pkg::OP_PROG: begin
          if (!high_voltage_enable || tick) begin
            state <= flash_pkg::OP_IDLE; // R4
          end
        end
        default: state <= flash_pkg::OP_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  excl_select_a: assert property (!(program_select && erase)) // R9
    else $error("program and erase both selected");
  hv_gate_a: assert property ($rose(high_voltage_enable) |-> (program_select || erase) // R6
    && $past(bpr_seen) && $past(addr_seen))
    else $error("high voltage set out of sequence");
  pump_follow_a: assert property (high_voltage_enable |=> PUMP_ON && ARRAY_HV) // R7
    else $error("pump not on after high voltage");
  pump_off_a: assert property (!high_voltage_enable |=> !PUMP_ON && !ARRAY_HV) // R7
    else $error("pump still on");
  margin_lock_a: assert property (high_voltage_enable |-> !margin) // R8
    else $error("margin set with high voltage");
  prot_clear_a: assert property (prot_hit |=> !program_select && !erase && !high_voltage_enable) // R17
    else $error("protected range not cleared");
  erase_step_a: assert property ((state == flash_pkg::OP_ERASE && high_voltage_enable // R5
    && tick && ptr != last) |=> ptr == $past(ptr) + 11'h001)
    else $error("erase walk skipped");
  prog_once_a: assert property ($rose(state == flash_pkg::OP_PROG) // R4
    |-> ##[1:3] state == flash_pkg::OP_IDLE)
    else $error("program did not finish");
  addr_hold_a: assert property ((addr_seen && $past(addr_seen)) // R16
    |-> $stable(addr))
    else $error("latched address moved");
  reset_zero_a: assert property (!$past(RSTN) |-> ctrl_byte == 8'h00) // R18
    else $error("control not clear after reset");

  erase_done_c: cover property (state == flash_pkg::OP_ERASE && tick
    && ptr == last && high_voltage_enable);
  prog_done_c: cover property (state == flash_pkg::OP_PROG && tick && high_voltage_enable);
  prot_hit_c: cover property (prot_hit);
endmodule
`default_nettype wire

//--- src/pump_clock_divider.sv
// Charge-pump clock enable derived from the bus clock.
// Assumes one clock; the tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps
`default_nettype none
module pump_clock_divider (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic div_by_two,
  output var  logic tick
);
  logic phase;

  // Tick every cycle for divide by one, every other cycle for two.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= 1'b0;
      tick  <= 1'b0;
    end else begin
      phase <= div_by_two ? ~phase : 1'b0; // R10
      tick  <= div_by_two ? phase : 1'b1;
    end
  end

  div_two_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (div_by_two && $past(div_by_two) && tick) |=> !tick)
    else $error("pump tick not halved");
  div_one_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (!div_by_two && !$past(div_by_two) && $past(rst_n)) |-> tick)
    else $error("pump tick missing at divide by one");
endmodule
`default_nettype wire

//--- tb/pump_model.sv
// Behavioural model of the charge pump and high-voltage switch.
// Assumes the pump enable, the array switch and the tick share one clock.
`timescale 1ns/1ps
`default_nettype none
module pump_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pump_on,
  input  wire logic        array_hv,
  input  wire logic        tick,
  output var  logic [15:0] ticks,
  output var  logic        split
);
  // Counts every pump clock so the bench can measure the divide ratio.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ticks <= 16'h0000;
    end else if (tick) begin
      ticks <= ticks + 16'h0001;
    end
  end

  // A pump running without the array switch, or the reverse, would stress
  // the cells, so any disagreement is remembered until the next reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      split <= 1'b0;
    end else if (pump_on !== array_hv) begin
      split <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_flash_program_erase_control.sv
// Self-checking bench for the flash program/erase control block.
// Assumes the shared flash package and the pump model under tb/.
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_control;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pump_on, array_hv, tick, split;
  logic [15:0] awaddr, araddr, ticks, t0;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          errors, cmp_count;
  logic [15:0] ea   [4] = '{16'h780c, 16'h7850, 16'h7900, 16'h7800};
  logic [15:0] ein  [4] = '{16'h7808, 16'h7840, 16'h7800, 16'h7c00};
  logic [15:0] eout [4] = '{16'h7810, 16'h7880, 16'h7c00, 16'h7c00};

  flash_program_erase_control flash_program_erase_control_inst (
    .REF_CLK(clk), .RSTN(rstn), .S_AWADDR(awaddr), .S_AWVALID(awvalid),
    .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(wstrb),
    .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp),
    .S_BVALID(bvalid), .S_BREADY(bready), .S_ARADDR(araddr),
    .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
    .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready),
    .PUMP_ON(pump_on), .ARRAY_HV(array_hv), .PUMP_CLK_TICK(tick)
  );

  pump_model pump_model_inst (
    .clk(clk), .rst_n(rstn), .pump_on(pump_on), .array_hv(array_hv),
    .tick(tick), .ticks(ticks), .split(split)
  );

  // Free-running 50 MHz bus clock.
  always #10 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      errors++;
    end
  endtask

  // Write cycle: address and data offered together, each dropped when taken.
  // An edge passes first, so a handshake lowered by the previous call is
  // never raised again in the same time step.
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      errors++;
      summarize;
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    d = 32'hffff_ffff;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      errors++;
      summarize;
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    rd(a, got, resp);
    chk(got, e);
  endtask

  task automatic ctl(input logic [7:0] v);
    wr(flash_pkg::CTRL_ADDR, {24'h000000, v}, 4'h1, resp);
  endtask

  // Waits for the pump, then polls busy; a stuck busy ends as a mismatch.
  task automatic run_op;
    int n;
    n = 0;
    while (pump_on !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, pump_on & array_hv}, 32'h1);
    if (pump_on !== 1'b1) summarize;
    n = 0;
    do begin
      rd(flash_pkg::CTRL_ADDR, got, resp);
      n++;
    end while (got[7] !== 1'b0 && n < 1000);
    chk({31'h0, got[7]}, 32'h0);
    if (got[7] !== 1'b0) summarize;
  endtask

  // One byte through the full program sequence, with a margin attempt while
  // high voltage is still on, which must be dropped.
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    ctl(8'h01);
    rd(flash_pkg::PROTECT_ADDR, got, resp);
    wr(a, {4{d}}, 4'h1 << a[1:0], resp);
    ctl(8'h09);
    run_op;
    ctl(8'h0d);
    rchk(flash_pkg::CTRL_ADDR, 32'h09);
    ctl(8'h01);
    repeat (2) @(posedge clk);
    chk({30'h0, pump_on, array_hv}, 32'h0);
    ctl(8'h00);
  endtask

  task automatic erase(input logic [15:0] a, input logic [1:0] sz);
    ctl({2'b00, sz, 4'h2});
    rd(flash_pkg::PROTECT_ADDR, got, resp);
    wr(a, 32'hffffffff, 4'h1, resp);
    ctl({2'b00, sz, 4'ha});
    run_op;
    ctl({2'b00, sz, 4'h2});
    ctl(8'h00);
  endtask

  // Main sequence; every row sees at most three programs between erases.
  initial begin
    clk = 1'b0; rstn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
    wstrb = '0; wvalid = 1'b0; bready = 1'b0; araddr = '0;
    arvalid = 1'b0; rready = 1'b0; errors = 0; cmp_count = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(flash_pkg::CTRL_ADDR, 32'h0);
    rchk(16'h7800, 32'h0);
    rd(16'h1000, got, resp);
    chk({got[31:2], resp}, {30'h0, flash_pkg::RESP_SLVERR});
    wr(16'h1000, 32'h1, 4'hf, resp);
    chk({30'h0, resp}, {30'h0, flash_pkg::RESP_SLVERR});
    for (int i = 0; i < 7; i++) begin
      ctl(8'h01 << i);
      rchk(flash_pkg::CTRL_ADDR, (i == 3) ? 32'h0 : (32'h1 << i));
      ctl(8'h00);
    end
    ctl(8'h70);
    rchk(flash_pkg::CTRL_ADDR, 32'h70);
    ctl(8'h00);
    ctl(8'h03);
    rchk(flash_pkg::CTRL_ADDR, 32'h0);
    ctl(8'h01);
    ctl(8'h03);
    rchk(flash_pkg::CTRL_ADDR, 32'h01);
    ctl(8'h00);
    for (int d = 0; d < 2; d++) begin
      ctl(d[0] ? 8'h40 : 8'h00);
      repeat (4) @(posedge clk);
      t0 = ticks;
      repeat (20) @(posedge clk);
      chk({16'h0, ticks - t0}, d[0] ? 32'd10 : 32'd20);
    end
    ctl(8'h00);
    prog(16'h780a, 8'ha5);
    rchk(16'h7808, 32'h00a50000);
    for (int k = 0; k < 4; k++) begin
      prog(ein[k], 8'h3c);
      prog(eout[k], 8'hc3);
      erase(ea[k], 2'(3 - k));
      rchk(ein[k], 32'h0);
      rchk(eout[k], (k == 3) ? 32'h0 : 32'h000000c3);
    end
    prog(16'hfff3, 8'h81);
    rchk(16'hfff0, 32'h81000000);
    prog(flash_pkg::PROTECT_ADDR, 8'h08);
    rchk(16'hfff0, 32'h81000008);
    prog(16'h7900, 8'h5a);
    rchk(16'h7900, 32'h0000005a);
    ctl(8'h01);
    rd(flash_pkg::PROTECT_ADDR, got, resp);
    wr(16'h7a00, 32'h77777777, 4'h1, resp);
    rchk(flash_pkg::CTRL_ADDR, 32'h0);
    // The select may be set again, but the sequence has restarted.
    ctl(8'h09);
    repeat (4) @(posedge clk);
    chk({31'h0, pump_on}, 32'h0);
    rchk(flash_pkg::CTRL_ADDR, 32'h01);
    rchk(16'h7a00, 32'h0);
    chk({31'h0, split}, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
